/* hdl/usa_pkg.sv */
// Constants shared by the serial port and its receive queue.
package usa_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_IRQ_FLAGS = 6'h10;
   localparam logic [5:0] IDX_IRQ_EN = 6'h11;
   localparam logic [5:0] IDX_RX_CTRL = 6'h13;
   localparam logic [5:0] IDX_RX_BUF = 6'h14;
   localparam logic [5:0] IDX_TX_CTRL = 6'h15;
   localparam logic [5:0] IDX_TX_BUF = 6'h16;
   localparam logic [5:0] IDX_BAUD = 6'h17;
   // Receive status and control fields
   localparam int RXC_PORT_EN = 7;
   localparam int RXC_NINTH_EN = 6;
   localparam int RXC_SINGLE = 5;
   localparam int RXC_CONT = 4;
   localparam int RXC_FRAMING_ERROR = 2;
   localparam int RXC_OVERRUN_ERROR = 1;
   localparam int RXC_NINTH = 0;
   // Transmit status and control fields
   localparam int TXC_CLK_SRC = 7;
   localparam int TXC_NINTH_EN = 6;
   localparam int TXC_EN = 5;
   localparam int TXC_SYNC = 4;
   localparam int TXC_SHIFT_EMPTY = 1;
   localparam int TXC_NINTH = 0;
   // Flag and enable fields
   localparam int IRQ_TX_BIT = 1;
   localparam int IRQ_RX_BIT = 0;
   // Reset values
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] TX_BUF_RST = 8'h00;
   // Oversampling phases of the three majority samples
   localparam logic [3:0] OVS_S1 = 4'h7;
   localparam logic [3:0] OVS_S2 = 4'h8;
   localparam logic [3:0] OVS_S3 = 4'h9;
   // Frame lengths in bits
   localparam logic [3:0] LEN8 = 4'h8;
   localparam logic [3:0] LEN9 = 4'h9;
   // Receive engine states
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_FRAME = 3'b010,
      RX_SYNC = 3'b100
   } usa_rx_state_t;
endpackage

/* hdl/usa_rxq_if.sv */
// Link between the receive engine and its two-entry queue.
interface usa_rxq_if;
   logic push;
   logic [9:0] wdata;
   logic pop;
   logic [9:0] head;
   logic full;
   logic empty;
   modport fill (output push, output wdata, output pop, input head, input full, input empty);
   modport store (input push, input wdata, input pop, output head, output full, output empty);
endinterface

/* hdl/usa_rx_queue.sv */
// Two-entry receive queue holding data, ninth bit and framing error.
module usa_rx_queue import usa_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   usa_rxq_if.store q
);
   logic [9:0] mem_reg [2];
   logic rd_reg;
   logic wr_reg;
   logic [1:0] cnt_reg;

   // Head entry and level flags
   assign q.head = mem_reg[rd_reg];
   assign q.full = (cnt_reg == 2'h2);
   assign q.empty = (cnt_reg == 2'h0);

   // Storage written only on push; contents need no reset
   always_ff @(posedge pclk) begin
      if (q.push && !q.full) begin
         mem_reg[wr_reg] <= q.wdata;
      end
   end

   // Pointers and level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (q.push && !q.full) begin
            wr_reg <= ~wr_reg;
         end
         if (q.pop && !q.empty) begin
            rd_reg <= ~rd_reg;
         end
         cnt_reg <= cnt_reg + {1'b0, q.push && !q.full} - {1'b0, q.pop && !q.empty};
      end
   end

   property p_queue_pop;
      @(posedge pclk) disable iff (!presetn)
      (q.pop && !q.push && cnt_reg == 2'h1) |=> q.empty;
   endproperty
   a_queue_pop: assert property (p_queue_pop) else $error("queue not empty after pop");
endmodule

/* hdl/usa_port.sv */
// Serial port: async receive, sync master transmit, APB registers.
// What this block does
// - Majority of three samples decides each async bit
// - Samples on oversampling edges seven, eight, nine
// - Oversampling count restarts at start edge, period sixteen
// - Dropping receive enables resets receiver to idle
// - Sync master is half duplex
// - Sync master claims pins: data with transmit enable, clock with transmit or receive
// - Clock source select drives shift clock
// - Shift register reloads only after last bit
// - Transfer empties buffer and sets transmit flag
// - Transmit flag cleared only by buffer write
// - Shift-empty bit shows shift register empty
// - Shifting waits for enable and loaded buffer
// - Data changes on rising shift clock edge
// - Baud generator held while all enables clear
// - Write to empty shifter passes straight through
// - Clearing transmit enable aborts, floats data, and clock unless receiving
// - Receive enable suspends transmit, floats data
// - Single receive clears itself, transmission resumes
// - Ninth transmit bit captured at transfer
// - Port or transmit disable resets transmitter
// - Receive buffer is two-entry queue with status
// - Overrun discards word, blocks until cleared
// - Low stop bit raises framing error
//
// The implementer's own choice: the APB slave port.
module usa_port import usa_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_n,
   input wire logic serial_timing_pin_in,
   output logic serial_timing_pin_out,
   output logic serial_timing_pin_oe_n
);
   // Control bits
   logic port_enable_reg, rx_ninth_bit_enable_reg, single_rx_enable_reg;
   logic continuous_rx_enable_reg, clock_source_select_reg, tx_ninth_bit_enable_reg;
   logic tx_enable_reg, sync_mode_reg, tx_ninth_bit_value_reg;
   logic [7:0] irq_en_reg, baud_divisor_reg, tx_buffer_reg;
   logic tx_buf_full_reg, overrun_error_reg;
   // Baud generator and pins
   logic [7:0] brg_cnt_reg;
   logic brg_run, brg_tick;
   logic din_meta_reg, din_reg, din_prev_reg;
   // Transmitter
   logic [8:0] tx_shift_register_reg;
   logic tx_full_reg;
   logic [3:0] tx_len_reg, tx_cnt_reg;
   logic dout_reg, sclk_reg, sclk_run, sclk_rise, sclk_fall;
   logic tx_on, tx_load, sync_master, rx_mode;
   // Receiver
   usa_rx_state_t rx_state_reg;
   logic [8:0] rx_shift_register_reg;
   logic [3:0] ovs_reg, rx_bit_reg, rx_len;
   logic [1:0] smp_reg;
   logic rx_on, async_on, decide, bit_val, rx_done;
   logic [9:0] rx_word;
   // Bus
   logic [5:0] idx;
   logic idx_ok, wr_en, rd_acc;
   logic [31:0] rd_word;
   usa_rxq_if q();

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // Pack a finished word as framing error, ninth bit, data
   function automatic logic [9:0] pack_word(input logic [8:0] sr, input logic nine,
                                            input logic framing_error);
      pack_word = nine ? {framing_error, sr} : {framing_error, 1'b0, sr[8:1]};
   endfunction

   usa_rx_queue u_queue (
      .pclk(pclk),
      .presetn(presetn),
      .q(q)
   );

   // APB decode; zero wait states
   assign idx = paddr[7:2];
   assign idx_ok = (idx == IDX_IRQ_FLAGS) || (idx == IDX_IRQ_EN) || (idx == IDX_RX_CTRL)
                   || (idx == IDX_RX_BUF) || (idx == IDX_TX_CTRL) || (idx == IDX_TX_BUF)
                   || (idx == IDX_BAUD);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !idx_ok;
   assign wr_en = psel && penable && pwrite && idx_ok;
   assign rd_acc = psel && penable && !pwrite;

   // Mode terms
   assign sync_master = port_enable_reg && sync_mode_reg && clock_source_select_reg;
   assign rx_on = port_enable_reg && (continuous_rx_enable_reg || single_rx_enable_reg);
   assign async_on = port_enable_reg && !sync_mode_reg && continuous_rx_enable_reg;
   assign rx_mode = rx_on && sync_mode_reg;
   assign tx_on = port_enable_reg && tx_enable_reg && sync_mode_reg;
   assign rx_len = rx_ninth_bit_enable_reg ? LEN9 : LEN8;

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (idx)
         IDX_IRQ_FLAGS: begin
            rd_word[IRQ_TX_BIT] = !tx_buf_full_reg;
            rd_word[IRQ_RX_BIT] = !q.empty;
         end
         IDX_IRQ_EN: rd_word[7:0] = irq_en_reg;
         IDX_RX_CTRL: begin
            rd_word[RXC_PORT_EN] = port_enable_reg;
            rd_word[RXC_NINTH_EN] = rx_ninth_bit_enable_reg;
            rd_word[RXC_SINGLE] = single_rx_enable_reg;
            rd_word[RXC_CONT] = continuous_rx_enable_reg;
            rd_word[RXC_FRAMING_ERROR] = q.head[9] && !q.empty;
            rd_word[RXC_OVERRUN_ERROR] = overrun_error_reg;
            rd_word[RXC_NINTH] = q.head[8] && !q.empty;
         end
         IDX_RX_BUF: rd_word[7:0] = q.head[7:0];
         IDX_TX_CTRL: begin
            rd_word[TXC_CLK_SRC] = clock_source_select_reg;
            rd_word[TXC_NINTH_EN] = tx_ninth_bit_enable_reg;
            rd_word[TXC_EN] = tx_enable_reg;
            rd_word[TXC_SYNC] = sync_mode_reg;
            rd_word[TXC_SHIFT_EMPTY] = !tx_full_reg;
            rd_word[TXC_NINTH] = tx_ninth_bit_value_reg;
         end
         IDX_TX_BUF: rd_word[7:0] = tx_buffer_reg;
         IDX_BAUD: rd_word[7:0] = baud_divisor_reg;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase so it is a flop at access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_word;
      end
   end

   // Reading the buffer advances the queue
   assign q.pop = rd_acc && (idx == IDX_RX_BUF);

   // Software control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_enable_reg <= 1'b0;
         rx_ninth_bit_enable_reg <= 1'b0;
         continuous_rx_enable_reg <= 1'b0;
         clock_source_select_reg <= 1'b0;
         tx_ninth_bit_enable_reg <= 1'b0;
         tx_enable_reg <= 1'b0;
         sync_mode_reg <= 1'b0;
         tx_ninth_bit_value_reg <= 1'b0;
         irq_en_reg <= IRQ_EN_RST;
         baud_divisor_reg <= BAUD_RST;
      end else if (wr_en) begin
         if (idx == IDX_RX_CTRL) begin
            port_enable_reg <= pwdata[RXC_PORT_EN];
            rx_ninth_bit_enable_reg <= pwdata[RXC_NINTH_EN];
            continuous_rx_enable_reg <= pwdata[RXC_CONT];
         end
         if (idx == IDX_TX_CTRL) begin
            clock_source_select_reg <= pwdata[TXC_CLK_SRC];
            tx_ninth_bit_enable_reg <= pwdata[TXC_NINTH_EN];
            tx_enable_reg <= pwdata[TXC_EN];
            sync_mode_reg <= pwdata[TXC_SYNC];
            tx_ninth_bit_value_reg <= pwdata[TXC_NINTH];
         end
         if (idx == IDX_IRQ_EN) begin
            irq_en_reg <= pwdata[7:0];
         end
         if (idx == IDX_BAUD) begin
            baud_divisor_reg <= pwdata[7:0];
         end
      end
   end

   // Single receive bit: software sets, hardware clears after one word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_rx_enable_reg <= 1'b0;
      end else if (wr_en && idx == IDX_RX_CTRL) begin
         single_rx_enable_reg <= pwdata[RXC_SINGLE];
      end else if (rx_done && rx_mode && !continuous_rx_enable_reg) begin
         single_rx_enable_reg <= 1'b0;
      end
   end

   // Flag clears only by buffer write, flag writes ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buffer_reg <= TX_BUF_RST;
         tx_buf_full_reg <= 1'b0;
      end else if (wr_en && idx == IDX_TX_BUF) begin
         tx_buffer_reg <= pwdata[7:0];
         tx_buf_full_reg <= 1'b1;
      end else if (tx_load) begin
         tx_buf_full_reg <= 1'b0;
      end
   end

   // Generator held unless an enable is set
   assign brg_run = port_enable_reg
                    && (tx_enable_reg || continuous_rx_enable_reg || single_rx_enable_reg);
   assign brg_tick = brg_run && (brg_cnt_reg == 8'h00);

   // Tick on the reload so the first shift clock comes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brg_cnt_reg <= 8'h00;
      end else if (!brg_run) begin
         brg_cnt_reg <= 8'h00;
      end else if (brg_tick) begin
         brg_cnt_reg <= baud_divisor_reg;
      end else begin
         brg_cnt_reg <= brg_cnt_reg - 8'h01;
      end
   end

   // Two-flop synchroniser on the data pin, then an edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_meta_reg <= 1'b1;
         din_reg <= 1'b1;
         din_prev_reg <= 1'b1;
      end else begin
         din_meta_reg <= serial_data_pin_in;
         din_reg <= din_meta_reg;
         if (brg_tick) begin
            din_prev_reg <= din_reg;
         end
      end
   end

   // Shift clock runs for a word or for reception
   assign sclk_run = sync_master && (rx_mode || (tx_on && tx_full_reg));
   assign sclk_rise = brg_tick && sclk_run && !sclk_reg;
   assign sclk_fall = brg_tick && sclk_run && sclk_reg;

   // Idle clock sits low so the first tick is a rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_reg <= 1'b0;
      end else if (!sclk_run) begin
         sclk_reg <= 1'b0;
      end else if (brg_tick) begin
         sclk_reg <= !sclk_reg;
      end
   end

   // Reload only when the shifter is empty
   // Needs enable and a loaded buffer
   // Writes into an empty shifter pass through
   assign tx_load = tx_on && clock_source_select_reg && !tx_full_reg && tx_buf_full_reg
                    && !rx_mode;

   // Transmit shifter; frozen, not reset, while receive owns the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift_register_reg <= 9'h000;
         tx_full_reg <= 1'b0;
         tx_len_reg <= LEN8;
         tx_cnt_reg <= 4'h0;
         dout_reg <= 1'b0;
      end else if (!tx_on) begin
         tx_full_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
      end else if (tx_load) begin
         // Ninth bit taken as it stands now
         tx_shift_register_reg <= {tx_ninth_bit_value_reg, tx_buffer_reg};
         tx_len_reg <= tx_ninth_bit_enable_reg ? LEN9 : LEN8;
         tx_full_reg <= 1'b1;
      end else if (!rx_mode && sclk_rise && tx_cnt_reg != tx_len_reg) begin
         // New bit on the rising edge, stable over falling
         dout_reg <= tx_shift_register_reg[0];
         tx_shift_register_reg <= {1'b0, tx_shift_register_reg[8:1]};
         tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end else if (!rx_mode && sclk_fall && tx_cnt_reg == tx_len_reg) begin
         tx_full_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
      end
   end

   assign bit_val = maj3(smp_reg[1], smp_reg[0], din_reg);
   // Decision on the ninth oversampling edge
   assign decide = brg_tick && rx_state_reg == RX_FRAME && (ovs_reg + 4'h1) == OVS_S3;

   // Receive engine: async frames or sync master words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_reg <= RX_IDLE;
         ovs_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         smp_reg <= 2'b00;
         rx_shift_register_reg <= 9'h000;
      end else if (!rx_on) begin
         rx_state_reg <= RX_IDLE;
         rx_bit_reg <= 4'h0;
      end else begin
         unique case (rx_state_reg)
            RX_IDLE: begin
               rx_bit_reg <= 4'h0;
               if (rx_mode) begin
                  // Receive takes the line from transmit
                  rx_state_reg <= RX_SYNC;
               end else if (async_on && brg_tick && din_prev_reg && !din_reg) begin
                  // Start edge aligns the phase count
                  rx_state_reg <= RX_FRAME;
                  ovs_reg <= 4'h0;
               end
            end
            RX_FRAME: begin
               if (brg_tick) begin
                  ovs_reg <= ovs_reg + 4'h1;
                  if (ovs_reg + 4'h1 == OVS_S1 || ovs_reg + 4'h1 == OVS_S2) begin
                     smp_reg <= {smp_reg[0], din_reg};
                  end
                  if (ovs_reg == 4'hf) begin
                     rx_bit_reg <= rx_bit_reg + 4'h1;
                  end
               end
               if (decide) begin
                  if (rx_bit_reg == 4'h0 && bit_val) begin
                     rx_state_reg <= RX_IDLE;
                  end else if (rx_bit_reg == rx_len + 4'h1) begin
                     rx_state_reg <= RX_IDLE;
                  end else if (rx_bit_reg != 4'h0) begin
                     rx_shift_register_reg <= {bit_val, rx_shift_register_reg[8:1]};
                  end
               end
            end
            RX_SYNC: begin
               if (!rx_mode) begin
                  rx_state_reg <= RX_IDLE;
               end else if (sclk_fall) begin
                  rx_shift_register_reg <= {din_reg, rx_shift_register_reg[8:1]};
                  rx_bit_reg <= (rx_bit_reg + 4'h1 == rx_len) ? 4'h0 : rx_bit_reg + 4'h1;
               end
            end
         endcase
      end
   end

   // Word complete: async stop decided, or last sync bit sampled
   always_comb begin
      rx_done = 1'b0;
      rx_word = 10'h000;
      if (decide && rx_bit_reg == rx_len + 4'h1) begin
         rx_done = 1'b1;
         // Low stop bit flags framing error
         rx_word = pack_word(rx_shift_register_reg, rx_ninth_bit_enable_reg, !bit_val);
      end else if (rx_state_reg == RX_SYNC && rx_mode && sclk_fall
                   && rx_bit_reg + 4'h1 == rx_len) begin
         rx_done = 1'b1;
         rx_word = pack_word({din_reg, rx_shift_register_reg[8:1]},
                             rx_ninth_bit_enable_reg, 1'b0);
      end
   end

   // Word and status enter the queue together
   assign q.push = rx_done && !q.full && !overrun_error_reg;
   assign q.wdata = rx_word;

   // Overrun set wins over clear by dropping continuous enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_error_reg <= 1'b0;
      end else if (rx_done && q.full) begin
         overrun_error_reg <= 1'b1;
      end else if (!continuous_rx_enable_reg || !port_enable_reg) begin
         overrun_error_reg <= 1'b0;
      end
   end

   // Data floats without transmit or for receive; clock floats without either
   assign serial_data_pin_out = dout_reg;
   assign serial_data_pin_oe_n = !(tx_on && clock_source_select_reg && !rx_mode);
   assign serial_timing_pin_out = sclk_reg;
   assign serial_timing_pin_oe_n = !(sync_master && (tx_enable_reg || rx_mode));

   property p_brg_hold;
      @(posedge pclk) disable iff (!presetn)
      !brg_run |-> !brg_tick && brg_cnt_reg == 8'h00 || $past(brg_run);
   endproperty
   a_brg_hold: assert property (p_brg_hold) else $error("baud generator ran while held");

   property p_half_duplex;
      @(posedge pclk) disable iff (!presetn)
      rx_mode |-> serial_data_pin_oe_n && !tx_load;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("data driven while receiving");

   property p_tx_abort;
      @(posedge pclk) disable iff (!presetn)
      !tx_enable_reg && !rx_on |-> serial_data_pin_oe_n && serial_timing_pin_oe_n;
   endproperty
   a_tx_abort: assert property (p_tx_abort) else $error("pins driven without enable");

   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
      wr_en && idx == IDX_TX_BUF |=> tx_buf_full_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("tx buffer not full after write");

   property p_load_empty;
      @(posedge pclk) disable iff (!presetn)
      tx_load && !(wr_en && idx == IDX_TX_BUF)
      |-> !tx_full_reg ##1 tx_full_reg && !tx_buf_full_reg;
   endproperty
   a_load_empty: assert property (p_load_empty) else $error("reload before shifter empty");

   property p_bit_out;
      @(posedge pclk) disable iff (!presetn)
      sclk_rise && tx_full_reg && !rx_mode && !tx_load && tx_cnt_reg != tx_len_reg
      |=> serial_data_pin_out == $past(tx_shift_register_reg[0]) && sclk_reg;
   endproperty
   a_bit_out: assert property (p_bit_out) else $error("data not changed on rising clock");

   property p_rx_reset;
      @(posedge pclk) disable iff (!presetn)
      !rx_on |=> rx_state_reg == RX_IDLE;
   endproperty
   a_rx_reset: assert property (p_rx_reset) else $error("receiver not idle when off");

   property p_overrun;
      @(posedge pclk) disable iff (!presetn)
      rx_done && q.full |-> !q.push ##1 overrun_error_reg;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_single_clear;
      @(posedge pclk) disable iff (!presetn)
      rx_done && rx_mode && !continuous_rx_enable_reg && !wr_en |=> !single_rx_enable_reg;
   endproperty
   a_single_clear: assert property (p_single_clear) else $error("single receive kept");
endmodule

/* tb/usa_peer.sv */
// Remote serial peer: async frame sender and sampler of the shift clock.
module usa_peer (
   dev_data,
   dev_data_oe_n,
   timing_line,
   line_level
);
   timeunit 1ns;
   timeprecision 1ns;
   input wire logic dev_data;
   input wire logic dev_data_oe_n;
   input wire logic timing_line;
   output logic line_level;
   logic drive_bit = 1'b1;
   logic [7:0] got = 8'h00;
   logic [7:0] first_word = 8'h00;
   int falls = 0;
   // Idle-high pulled line; the device wins while it drives
   assign line_level = dev_data_oe_n ? drive_bit : dev_data;
   // Data is stable around the falling edge, so sample there, LSB first
   always @(negedge timing_line) begin
      got <= {line_level, got[7:1]};
      falls <= falls + 1;
      // Keep the first word so back-to-back words stay apart
      if (falls == 7) begin
         first_word <= {line_level, got[7:1]};
      end
   end
   // Start bit, eight data bits, chosen stop level, then idle
   task automatic send(input logic [7:0] d, input logic stop);
      drive_bit <= 1'b0;
      #800;
      for (int i = 0; i < 8; i++) begin
         drive_bit <= d[i];
         #800;
      end
      drive_bit <= stop;
      #800;
      drive_bit <= 1'b1;
      #1600;
   endtask
endmodule

/* tb/test_usart_async_rx_sync_master_tx.sv */
// Bench for the serial port: registers, sync transmit, async receive.
module test_usart_async_rx_sync_master_tx;
   import usa_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rd_err, d_out, d_oe_n, t_out, t_oe_n, line, t_line;
   int num_errors = 0, tests_run = 0;
   // Clock line floats low when released
   assign t_line = t_oe_n ? 1'b0 : t_out;
   always #25 pclk = ~pclk;
   usa_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_data_pin_in(line), .serial_data_pin_out(d_out),
      .serial_data_pin_oe_n(d_oe_n), .serial_timing_pin_in(t_line),
      .serial_timing_pin_out(t_out), .serial_timing_pin_oe_n(t_oe_n));
   usa_peer peer (.dev_data(d_out), .dev_data_oe_n(d_oe_n), .timing_line(t_line),
      .line_level(line));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_reset;
      apb(1'b0, IDX_TX_CTRL, 8'h00);
      check(rd, 32'h02);
      apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      check(rd, 32'h02);
      apb(1'b0, 6'h3f, 8'h00);
      check({31'h0, rd_err}, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_sync_tx;
      apb(1'b1, IDX_BAUD, 8'h03);
      apb(1'b1, IDX_RX_CTRL, 8'h80);
      apb(1'b1, IDX_TX_CTRL, 8'hb0);
      peer.got = 8'h00;
      peer.falls = 0;
      apb(1'b1, IDX_TX_BUF, 8'ha5);
      apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      check(rd[1], 1'b1);
      check({d_oe_n, t_oe_n}, 2'b00);
      apb(1'b1, IDX_TX_BUF, 8'h3c);
      apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      check(rd[1], 1'b0);
      // Second word must not load until the first has fully gone out
      repeat (100) apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      check(peer.first_word, 8'ha5);
      check(rd[1], 1'b1);
      repeat (60) apb(1'b0, IDX_TX_CTRL, 8'h00);
      check(peer.got, 8'h3c);
      check(rd, 32'hb2);
      check(peer.falls, 32'd16);
      // Single receive takes the line, then hands it back to transmit
      apb(1'b1, IDX_RX_CTRL, 8'ha0);
      apb(1'b0, IDX_RX_CTRL, 8'h00);
      check({d_oe_n, t_oe_n}, 2'b10);
      repeat (30) apb(1'b0, IDX_RX_CTRL, 8'h00);
      check(rd, 32'h80);
      check(d_oe_n, 1'b0);
      apb(1'b0, IDX_RX_BUF, 8'h00);
      check(rd, 32'hff);
      apb(1'b1, IDX_TX_CTRL, 8'h90);
      // Pins follow the write only after its edge has settled
      @(negedge pclk);
      check({d_oe_n, t_oe_n}, 2'b11);
      $display("sync transmit test done");
   endtask
   task automatic t_async_rx;
      // Async mode, divisor, then receive enable
      apb(1'b1, IDX_TX_CTRL, 8'h00);
      apb(1'b1, IDX_BAUD, 8'h00);
      apb(1'b1, IDX_RX_CTRL, 8'h90);
      peer.send(8'h3c, 1'b1);
      peer.send(8'h5a, 1'b0);
      apb(1'b0, IDX_RX_CTRL, 8'h00);
      check(rd, 32'h90);
      apb(1'b0, IDX_RX_BUF, 8'h00);
      check(rd, 32'h3c);
      apb(1'b0, IDX_RX_CTRL, 8'h00);
      check(rd, 32'h94);
      apb(1'b0, IDX_RX_BUF, 8'h00);
      check(rd, 32'h5a);
      for (int i = 0; i < 3; i++) peer.send(8'h11 << i, 1'b1);
      apb(1'b0, IDX_RX_CTRL, 8'h00);
      check(rd, 32'h92);
      apb(1'b1, IDX_RX_CTRL, 8'h80);
      apb(1'b1, IDX_RX_CTRL, 8'h90);
      apb(1'b0, IDX_RX_CTRL, 8'h00);
      check(rd, 32'h90);
      apb(1'b0, IDX_RX_BUF, 8'h00);
      check(rd, 32'h11);
      $display("async receive test done");
   endtask
   // Watchdog sized well beyond the expected run
   initial begin
      #3000000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_sync_tx();
      t_async_rx();
      close_out();
   end
endmodule
